//--- rtl/peep_buf_if.sv
/*
 * peep_buf_if: page buffer write and read ports.
 * assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface peep_buf_if #(
    parameter int DW = 8,
    parameter int AW = 6
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport mem (
        input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
        output rd_data
    );
    modport ctl (
        output wr_en, wr_addr, wr_data, rd_en, rd_addr,
        input  rd_data
    );
endinterface

//--- rtl/peep_host.sv
/*
 * peep_host: eeprom host; reads, page writes, then polls bit 7 or 6.
 * assumes synchronous pin inputs and data lines resolved outside.
 */
// Operation
// - select low for every access, else standby
// - write needs select, strobe low, gate high
// - upper seven address bits fixed per page
// - next load within 100 us of last
`timescale 1ns/1ps
module peep_host
    import peep_pkg::*;
#(
    parameter int WC_LIMIT = WC_CYC   // polling timeout in cycles
) (
    // clock, reset, enable
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    // page buffer fill
    input  wire logic                 fill_valid,
    input  wire logic [PAGE_LO_W-1:0] fill_index,
    input  wire logic [DATA_W-1:0]    fill_data,
    // command
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_write,
    input  wire logic [ADDR_W-1:0]    cmd_addr,
    input  wire logic [LEN_W-1:0]     cmd_len,
    input  wire logic                 cmd_poll_toggle,
    output logic                      cmd_ready,
    // response
    output logic                      rsp_valid,
    output logic                      rsp_timeout,
    output logic [DATA_W-1:0]         rsp_data,
    // memory pins
    output logic                      mem_ce_n,
    output logic                      mem_oe_n,
    output logic                      mem_we_n,
    output logic [ADDR_W-1:0]         mem_addr,
    output logic [DATA_W-1:0]         mem_data_out,
    output logic                      mem_data_oe,
    input  wire logic [DATA_W-1:0]    mem_data_in
);

    // ************************************************************
    // constants at counter width
    // ************************************************************
    localparam logic [CNT_W-1:0] RD_CNT  = CNT_W'(RD_CYC);
    localparam logic [CNT_W-1:0] WP_CNT  = CNT_W'(WP_CYC - 1);
    localparam logic [CNT_W-1:0] BLC_CNT = CNT_W'(BLC_CYC);
    localparam logic [WC_W-1:0]  WC_CNT  = WC_W'(WC_LIMIT);

    peep_state_t            state, next_state;
    logic [CNT_W-1:0]       cnt, next_cnt;
    logic [WC_W-1:0]        wt, next_wt;
    logic [PAGE_LO_W-1:0]   idx, next_idx;
    logic [PAGE_LO_W-1:0]   last_idx, next_last_idx;
    logic [PAGE_LO_W-1:0]   lo, next_lo;
    logic [PAGE_HI_W-1:0]   page, next_page;
    logic                   tog_mode, next_tog_mode;
    logic                   prev6, next_prev6;
    logic                   have_prev, next_have_prev;
    logic [DATA_W-1:0]      last_data, next_last_data;
    logic [DATA_W-1:0]      next_rsp_data;
    logic [ADDR_W-1:0]      next_addr;
    logic                   next_rsp_valid;
    logic                   next_rsp_timeout;

    peep_buf_if #(.DW(DATA_W), .AW(PAGE_LO_W)) buf_bus ();

    peep_page_mem #(.DW(DATA_W), .AW(PAGE_LO_W)) u_mem (
        .sys_clk (sys_clk),
        .bus     (buf_bus)
    );

    // ************************************************************
    // decode
    // ************************************************************
    // read address leads idx by one edge so rd_data is ready in setup
    assign buf_bus.wr_en   = fill_valid & clk_en;
    assign buf_bus.wr_addr = fill_index;
    assign buf_bus.wr_data = fill_data;
    assign buf_bus.rd_en   = clk_en;
    assign buf_bus.rd_addr = next_idx;

    wire cnt_zero  = (cnt == '0);
    wire wt_zero   = (wt == '0);
    wire last_byte = (idx == last_idx);
    // length zero is taken as one byte, never as an empty page
    wire [PAGE_LO_W-1:0] len_m1 = (cmd_len == '0) ? '0 :
                                  PAGE_LO_W'(cmd_len - LEN_W'(1));
    wire [PAGE_LO_W-1:0] lo_next = PAGE_LO_W'(lo + idx + PAGE_LO_W'(1));
    // bit 7 matches the written value only once programming is over
    wire poll7_done = (rsp_data[POLL_BIT] == last_data[POLL_BIT]);
    // two reads in a row with the same bit 6 mean toggling stopped
    wire poll6_done = have_prev && (rsp_data[TOGG_BIT] == prev6);
    wire poll_done  = tog_mode ? poll6_done : poll7_done;

    // pin levels as a function of the state being entered
    wire sel_on  = (next_state == PEEP_RD) || (next_state == PEEP_POLL_RD)
                || (next_state == PEEP_WR_SETUP)
                || (next_state == PEEP_WR_PULSE)
                || (next_state == PEEP_WR_HOLD);
    wire gate_on = (next_state == PEEP_RD)
                || (next_state == PEEP_POLL_RD);
    // strobe low only in the pulse, where the gate is always high
    wire strb_on = (next_state == PEEP_WR_PULSE);
    wire drv_on  = (next_state == PEEP_WR_PULSE)
                || (next_state == PEEP_WR_HOLD);

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_state       = state;
        next_cnt         = cnt;
        next_wt          = wt;
        next_idx         = idx;
        next_last_idx    = last_idx;
        next_lo          = lo;
        next_page        = page;
        next_tog_mode    = tog_mode;
        next_prev6       = prev6;
        next_have_prev   = have_prev;
        next_last_data   = last_data;
        next_rsp_data    = rsp_data;
        next_addr        = mem_addr;
        next_rsp_valid   = 1'b0;
        next_rsp_timeout = 1'b0;
        case (state)
            PEEP_IDLE: begin
                if (cmd_valid) begin
                    next_addr = cmd_addr;
                    if (cmd_write) begin
                        next_page     = cmd_addr[ADDR_W-1:PAGE_LO_W];
                        next_lo       = cmd_addr[PAGE_LO_W-1:0];
                        next_idx      = '0;
                        next_last_idx = len_m1;
                        next_tog_mode = cmd_poll_toggle;
                        next_state    = PEEP_WR_SETUP;
                    end else begin
                        next_cnt   = RD_CNT;
                        next_state = PEEP_RD;
                    end
                end
            end
            PEEP_RD: begin
                if (cnt_zero) begin
                    next_rsp_data  = mem_data_in;
                    next_rsp_valid = 1'b1;
                    next_state     = PEEP_IDLE;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            PEEP_WR_SETUP: begin
                // address stands a full cycle before the falling strobe
                next_cnt   = WP_CNT;
                next_state = PEEP_WR_PULSE;
            end
            PEEP_WR_PULSE: begin
                if (cnt_zero) begin
                    next_state = PEEP_WR_HOLD;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            PEEP_WR_HOLD: begin
                // data stays driven through the rising strobe edge
                if (last_byte) begin
                    next_last_data = mem_data_out;
                    next_cnt       = BLC_CNT;
                    next_state     = PEEP_WIN_WAIT;
                end else begin
                    // loads follow within a few cycles, far inside 100 us
                    next_idx   = idx + PAGE_LO_W'(1);
                    next_addr  = {page, lo_next};
                    next_state = PEEP_WR_SETUP;
                end
            end
            PEEP_WIN_WAIT: begin
                // a read inside the load window would disturb the page
                if (cnt_zero) begin
                    next_cnt       = RD_CNT;
                    next_wt        = WC_CNT;
                    next_have_prev = 1'b0;
                    next_state     = PEEP_POLL_RD;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            PEEP_POLL_RD: begin
                if (!wt_zero) begin
                    next_wt = wt - WC_W'(1);
                end
                if (cnt_zero) begin
                    next_rsp_data = mem_data_in;
                    next_state    = PEEP_POLL_CHK;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            PEEP_POLL_CHK: begin
                // gate high here, so every poll is a separate read
                if (poll_done) begin
                    next_rsp_valid = 1'b1;
                    next_state     = PEEP_IDLE;
                end else if (wt_zero) begin
                    // a protected device never resolves bit 7 polling
                    next_rsp_valid   = 1'b1;
                    next_rsp_timeout = 1'b1;
                    next_state       = PEEP_IDLE;
                end else begin
                    next_wt        = wt - WC_W'(1);
                    next_prev6     = rsp_data[TOGG_BIT];
                    next_have_prev = 1'b1;
                    next_cnt       = RD_CNT;
                    next_state     = PEEP_POLL_RD;
                end
            end
            default: begin
                next_state = PEEP_IDLE;
            end
        endcase
    end

    // ************************************************************
    // state registers
    // ************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= PEEP_IDLE;
            cnt       <= '0;
            wt        <= '0;
            idx       <= '0;
            last_idx  <= '0;
            lo        <= '0;
            page      <= '0;
            tog_mode  <= 1'b0;
            prev6     <= 1'b0;
            have_prev <= 1'b0;
            last_data <= '0;
        end else if (clk_en) begin
            state     <= next_state;
            cnt       <= next_cnt;
            wt        <= next_wt;
            idx       <= next_idx;
            last_idx  <= next_last_idx;
            lo        <= next_lo;
            page      <= next_page;
            tog_mode  <= next_tog_mode;
            prev6     <= next_prev6;
            have_prev <= next_have_prev;
            last_data <= next_last_data;
        end
    end

    // ************************************************************
    // output registers
    // ************************************************************
    // strobes idle high so reset leaves the device deselected
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_ready   <= 1'b0;
            rsp_valid   <= 1'b0;
            rsp_timeout <= 1'b0;
            rsp_data    <= '0;
            mem_ce_n    <= 1'b1;
            mem_oe_n    <= 1'b1;
            mem_we_n    <= 1'b1;
            mem_addr    <= '0;
            mem_data_oe <= 1'b0;
        end else if (clk_en) begin
            cmd_ready   <= (next_state == PEEP_IDLE);
            rsp_valid   <= next_rsp_valid;
            rsp_timeout <= next_rsp_timeout;
            rsp_data    <= next_rsp_data;
            mem_ce_n    <= !sel_on;
            mem_oe_n    <= !gate_on;
            mem_we_n    <= !strb_on;
            mem_addr    <= next_addr;
            mem_data_oe <= drv_on;
        end
    end

    // write data loads as the strobe falls, from the buffer word
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_data_out <= '0;
        end else if (clk_en && state == PEEP_WR_SETUP) begin
            mem_data_out <= buf_bus.rd_data;
        end
    end

endmodule

//--- rtl/peep_page_mem.sv
/*
 * peep_page_mem: one page of bytes, registered read data.
 * assumes the owner holds rd_en low whenever the clock enable is low.
 */
`timescale 1ns/1ps
module peep_page_mem #(
    parameter int DW = 8,
    parameter int AW = 6
) (
    // clock
    input  wire logic sys_clk,
    // buffer port
    peep_buf_if.mem   bus
);

    logic [DW-1:0] store [2**AW];

    // ************************************************************
    // storage
    // ************************************************************
    // no reset: contents are only read after the user has filled them
    always_ff @(posedge sys_clk) begin
        if (bus.wr_en) begin
            store[bus.wr_addr] <= bus.wr_data;
        end
        if (bus.rd_en) begin
            bus.rd_data <= store[bus.rd_addr];
        end
    end

endmodule

//--- rtl/peep_pkg.sv
/*
 * peep_pkg: constants, states and a cycle helper for the host.
 * assumes one 20 MHz clock; all counts derive from it.
 */
package peep_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_NS      = 50;      // 20 MHz system clock
    localparam int T_ACC_NS    = 150;     // read access time
    localparam int T_WP_NS     = 100;     // write strobe low width
    localparam int T_BLC_US    = 100;     // byte load window
    localparam int T_WC_MS     = 5;       // typical programming time

    // least times round up to whole cycles, never below one
    function automatic int peep_cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int RD_CYC  = peep_cyc_up(T_ACC_NS);
    localparam int WP_CYC  = peep_cyc_up(T_WP_NS);
    localparam int BLC_CYC = peep_cyc_up(T_BLC_US * 1000);
    localparam int WC_CYC  = peep_cyc_up(T_WC_MS * 1000000);

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int ADDR_W    = 13;        // byte address width
    localparam int DATA_W    = 8;         // data line width
    localparam int PAGE_LO_W = 6;         // offset within a page
    localparam int PAGE_HI_W = ADDR_W - PAGE_LO_W;
    localparam int LEN_W     = 7;         // byte count 1..64
    localparam int CNT_W     = 12;        // short interval counter
    localparam int WC_W      = 17;        // polling timeout counter
    localparam int POLL_BIT  = 7;         // complemented-bit line
    localparam int TOGG_BIT  = 6;         // toggling line

    // ************************************************************
    // controller states
    // ************************************************************
    typedef enum logic [3:0] {
        PEEP_IDLE     = 4'h0,
        PEEP_RD       = 4'h1,
        PEEP_WR_SETUP = 4'h2,
        PEEP_WR_PULSE = 4'h3,
        PEEP_WR_HOLD  = 4'h4,
        PEEP_WIN_WAIT = 4'h5,
        PEEP_POLL_RD  = 4'h6,
        PEEP_POLL_CHK = 4'h7
    } peep_state_t;

endpackage

//--- tb/peep_host_monitor.sv
/*
 * peep_host_monitor: peep_host pin assertions; assumes clk_en high.
 */
`timescale 1ns/1ps
module peep_host_monitor
    import peep_pkg::*;
(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              clk_en,
    // command and response
    input wire logic              cmd_valid,
    input wire logic              cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic              cmd_poll_toggle,
    input wire logic              cmd_ready,
    input wire logic              rsp_valid,
    input wire logic              rsp_timeout,
    input wire logic [DATA_W-1:0] rsp_data,
    // memory pins
    input wire logic              mem_ce_n,
    input wire logic              mem_oe_n,
    input wire logic              mem_we_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic              mem_data_oe,
    input wire logic [DATA_W-1:0] mem_data_in
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // ************************************************************
    // helper state
    // ************************************************************
    logic              in_wr;
    logic              tog_q;
    logic              last_b7;
    logic              loaded;
    logic              we_q;
    logic [ADDR_W-1:0] exp_addr;
    logic [11:0]       since;
    wire take = clk_en && cmd_valid && cmd_ready;
    wire fall = we_q && !mem_we_n;
    wire rise = !we_q && mem_we_n;

    // since counts from the last falling strobe, saturating at 4095
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_wr    <= 1'b0;
            tog_q    <= 1'b0;
            last_b7  <= 1'b0;
            loaded   <= 1'b0;
            we_q     <= 1'b1;
            exp_addr <= '0;
            since    <= '0;
        end else begin
            we_q    <= mem_we_n;
            since   <= fall ? 12'h000 : since + {11'h000, ~&since};
            loaded  <= take ? 1'b0 : (loaded | fall);
            last_b7 <= fall ? mem_data_out[7] : last_b7;
            tog_q   <= take ? cmd_poll_toggle : tog_q;
            in_wr   <= take ? cmd_write : (in_wr && !rsp_valid);
            if (take) begin
                exp_addr <= cmd_addr;
            end else if (rise) begin
                exp_addr[5:0] <= exp_addr[5:0] + 6'h01;
            end
        end
    end

    a_write_gate: assert property (
        !mem_we_n |-> mem_oe_n && !mem_ce_n)
        else $error("strobe low outside a write");
    a_gate_float: assert property (mem_data_oe |-> mem_oe_n)
        else $error("data driven with gate low");
    a_read_walk: assert property (take && !cmd_write |=>
        (!mem_ce_n && !mem_oe_n)[*4] ##1 (rsp_valid && mem_ce_n && mem_oe_n))
        else $error("read walk wrong");
    a_read_addr: assert property (take && !cmd_write |=>
        mem_addr == $past(cmd_addr))
        else $error("read address wrong");
    a_read_data: assert property (rsp_valid && !$past(mem_oe_n) |->
        rsp_data == $past(mem_data_in))
        else $error("read data wrong");
    a_page_addr: assert property (
        fall && in_wr |-> mem_addr == exp_addr)
        else $error("load address wrong");
    a_strobe_hold: assert property (fall |-> ##1 (!mem_ce_n
        && mem_data_oe && $stable(mem_data_out)
        && $stable(mem_addr))[*2] ##1 mem_we_n)
        else $error("strobe hold wrong");
    a_load_window: assert property (fall && in_wr && loaded |->
        since < BLC_CYC)
        else $error("load after window");
    a_poll_after: assert property ($fell(mem_oe_n) && in_wr |->
        since >= BLC_CYC)
        else $error("poll inside window");
    a_rsp_ready: assert property (rsp_valid |-> cmd_ready && !$past(cmd_ready))
        else $error("answer without ready");
    a_timeout_pair: assert property (rsp_timeout |-> rsp_valid)
        else $error("timeout without answer");
    a_poll_true: assert property (rsp_valid && in_wr && !tog_q
        && !rsp_timeout |-> rsp_data[7] == last_b7)
        else $error("bit 7 not true at done");
endmodule

bind peep_host peep_host_monitor u_mon (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_poll_toggle(cmd_poll_toggle), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_timeout(rsp_timeout), .rsp_data(rsp_data),
    .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .mem_addr(mem_addr), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in)
);

//--- tb/peep_mem_model.sv
/*
 * peep_mem_model: eeprom model with load window and busy polling.
 * assumes pins change just after sys_clk edges.
 */
`timescale 1ns/1ps
module peep_mem_model
    import peep_pkg::*;
#(
    parameter int PROG_CYC = 60,  // shortened programming time
    parameter int ACC_CYC  = 3    // cycles before read data is valid
) (
    // clock and strap
    input  wire logic              sys_clk,
    input  wire logic              write_protect,
    // memory pins
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [ADDR_W-1:0] byte_address,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_lines
);
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] pend [0:63];
    logic [63:0]       pend_v = '0;
    logic [ADDR_W-1:0] lat_addr = '0;
    logic [ADDR_W-1:0] last_addr = '0;
    logic [DATA_W-1:0] last_d = '0;
    logic [DATA_W-1:0] prev_out = '0;
    logic              wr_q = 1'b0;
    logic              rd_q = 1'b0;
    logic              loading = 1'b0;
    logic              busy = 1'b0;
    logic              tog = 1'b0;
    int                since = 0;
    int                prog = 0;
    int                acc = 0;
    wire wr_on = !ce_n && !we_n && oe_n;
    wire rd_on = !ce_n && !oe_n;
    wire [DATA_W-1:0] busy_val = {~last_d[7], tog, last_d[5:0]};

    // floating lines flip each cycle so a stale value never passes
    assign data_lines = (rd_on && acc >= ACC_CYC) ?
        (busy ? busy_val : cells[byte_address]) : ~prev_out;

    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            cells[i] = 8'hff;
        end
    end

    // load window, programming and toggle state
    always @(posedge sys_clk) begin
        wr_q <= wr_on;
        rd_q <= rd_on;
        prev_out <= data_lines;
        acc <= rd_on ? acc + 1 : 0;
        if (wr_on && !wr_q && !busy && !write_protect) begin
            lat_addr <= byte_address;
            loading <= 1'b1;
            since <= 0;
        end else if (loading && since == BLC_CYC) begin
            loading <= 1'b0;
            busy <= 1'b1;
            prog <= 0;
        end else if (loading) begin
            since <= since + 1;
        end
        if (!wr_on && wr_q && loading) begin
            pend[lat_addr[5:0]] <= data_in;
            pend_v[lat_addr[5:0]] <= 1'b1;
            last_addr <= lat_addr;
            last_d <= data_in;
        end
        if (busy) begin
            prog <= prog + 1;
            if (prog == PROG_CYC) begin
                for (int i = 0; i < 64; i++) begin
                    if (pend_v[i]) begin
                        cells[{last_addr[12:6], 6'(i)}] <= pend[i];
                    end
                end
                pend_v <= '0;
                busy <= 1'b0;
            end
        end
        if (rd_on && !rd_q && busy) begin
            tog <= ~tog;
        end
    end
endmodule

//--- tb/tb.sv
/*
 * tb: directed bench for peep_host against peep_mem_model.
 * assumes 20 MHz clock and a shortened polling limit.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    errors++; $display("ERROR t=%0t got %h exp %h", $time, got, \
    exp); end end
module tb;
    import peep_pkg::*;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              fill_valid = 1'b0;
    logic [5:0]        fill_index = '0;
    logic [DATA_W-1:0] fill_data = '0;
    logic              cmd_valid = 1'b0;
    logic              cmd_write = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [LEN_W-1:0]  cmd_len = 7'h01;
    logic              cmd_poll_toggle = 1'b0;
    logic              write_protect = 1'b0;
    logic              cmd_ready, rsp_valid, rsp_timeout;
    logic              mem_ce_n, mem_oe_n, mem_we_n, mem_data_oe;
    logic [DATA_W-1:0] rsp_data, mem_data_out, dev_lines;
    logic [ADDR_W-1:0] mem_addr;
    wire  [DATA_W-1:0] mem_data_in = mem_data_oe ? mem_data_out : dev_lines;
    int                errors = 0;
    int                n_tests = 0;
    int                lat;

    peep_host #(.WC_LIMIT(200)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .fill_valid(fill_valid), .fill_index(fill_index),
        .fill_data(fill_data), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .cmd_poll_toggle(cmd_poll_toggle), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_timeout(rsp_timeout),
        .rsp_data(rsp_data), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
        .mem_we_n(mem_we_n), .mem_addr(mem_addr),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
        .mem_data_in(mem_data_in)
    );
    peep_mem_model u_dev (
        .sys_clk(sys_clk), .write_protect(write_protect),
        .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
        .byte_address(mem_addr), .data_in(mem_data_in),
        .data_lines(dev_lines)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // request held until taken, then answer waited for with a bound
    task automatic run_cmd(input logic wr, input logic [ADDR_W-1:0] a,
                           input logic [LEN_W-1:0] n, input logic tg);
        cmd_write = wr;
        cmd_addr = a;
        cmd_len = n;
        cmd_poll_toggle = tg;
        cmd_valid = 1'b1;
        for (int k = 0; k < 50 && cmd_ready !== 1'b1; k++) begin
            @(posedge sys_clk) #1;
        end
        @(posedge sys_clk) #1;
        cmd_valid = 1'b0;
        for (lat = 1; lat < 8000 && rsp_valid !== 1'b1; lat++) begin
            @(posedge sys_clk) #1;
        end
        `CHK(rsp_valid, 1'b1)
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] e);
        run_cmd(1'b0, a, 7'h01, 1'b0);
        `CHK(rsp_data, e)
        `CHK(lat, 5)
    endtask

    task automatic fill(input int n, input logic [DATA_W-1:0] x);
        for (int i = 0; i < n; i++) begin
            fill_valid = 1'b1;
            fill_index = 6'(i);
            fill_data = 8'(i) ^ x;
            @(posedge sys_clk) #1;
        end
        fill_valid = 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        `CHK(mem_ce_n, 1'b1)
        `CHK(mem_data_oe, 1'b0)
        `CHK(cmd_ready, 1'b0)
        $display("done t_reset");
    endtask

    // lone byte whose bit 7 differs from the erased cell
    task automatic t_byte_write;
        rd_chk(13'h1fff, 8'hff);
        fill(1, 8'h3c);
        run_cmd(1'b1, 13'h0040, 7'h01, 1'b0);
        `CHK(rsp_timeout, 1'b0)
        `CHK(rsp_data, 8'h3c)
        rd_chk(13'h0040, 8'h3c);
        rd_chk(13'h0041, 8'hff);
        $display("done t_byte_write");
    endtask

    // full page starting mid-page so the offset wraps, toggle polling
    task automatic t_page_toggle;
        fill(64, 8'ha5);
        run_cmd(1'b1, 13'h07c5, 7'h40, 1'b1);
        `CHK(rsp_timeout, 1'b0)
        for (int i = 0; i < 64; i++) begin
            rd_chk({7'h1f, 6'(5 + i)}, 8'(i) ^ 8'ha5);
        end
        $display("done t_page_toggle");
    endtask

    // protected part never ends bit 7 polling, so the host times out
    task automatic t_protected;
        write_protect = 1'b1;
        fill(1, 8'h12);
        run_cmd(1'b1, 13'h0100, 7'h01, 1'b0);
        `CHK(rsp_timeout, 1'b1)
        write_protect = 1'b0;
        rd_chk(13'h0100, 8'hff);
        $display("done t_protected");
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        t_reset();
        sys_rst = 1'b0;
        @(posedge sys_clk) #1;
        t_byte_write();
        t_page_toggle();
        t_protected();
        tally_and_finish();
    end

    // watchdog well above the roughly 7000 cycles the tests need
    initial begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        tally_and_finish();
    end
endmodule
